/* File: cif_inject.sv */
// Purpose: Merge two CPU injection groups into the core CPU port and parse the injection header.
// Assumes: Beats are synchronous to clk; AXI4-Lite master keeps one write and one read in flight.
// Notes:   Payload moves at one beat per two cycles so every ready output is a flop.
`timescale 1ns/10ps
`include "cif_defs.svh"

// Functional notes
// - Two independent injection groups, ports 11 and 12, each with its own input.
// - Every injected frame is presented to the core as arriving on port 11.
// - Precedence setting marks CPU frames for priority into egress queues.
// - First 20 bytes of each frame are the processing header, not payload.
// - Header parsed only for groups whose inject_header_enable is set.
// - Skip set: forward by mask, queue, class; pass tag fields to rewriter.
// - Skip clear: destination, class and VLAN left to normal analysis.
// - Bit 126 with skip clear impersonates the port in the 4-bit field.
// - Bit 126 with skip set replaces source MAC with egress port setting.
// - Command is nine bits at 117, applied only with skip; low nibble 0 is nop.
// - Low nibble 8 swaps MAC addresses and clears bit 40 of new source MAC.
// - Low three bits 1: command bits 8..3 are the DSCP for remarking.
// - Low three bits 2: one-step PTP; bit 5 adds egress delay.
// - Low three bits 3: two-step PTP stamp stored under id in bits 8..3.
// - Low three bits 5: departure time of day into origin stamp field.
// - Forward mask is twelve bits at 56, top bit CPU, used only with skip.
// - Ingress port number is four bits at 43, value 0 to 12.
// - Thirty-two bit value at 85 is the injection start time for residence.
module cif_inject (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic [7:0]               s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [7:0]               s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	input  wire logic [1:0]               in_valid,
	input  wire cif_pkg::cif_beat_t [1:0] in_beat,
	output logic [1:0]                    in_ready,
	output logic                          out_valid,
	output cif_pkg::cif_beat_t            out_beat,
	output logic                          out_sof,
	output cif_pkg::cif_desc_t            out_desc,
	input  wire logic                     out_ready,
	output logic [47:0]                   egress_smac,
	output logic                          cpu_source_precedence
);

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Header fields to descriptor; rewriter ops only under skip, impersonation only without
	function automatic cif_pkg::cif_desc_t decode_hdr(input logic [127:0] h, input logic grp, input logic pref);
		cif_pkg::cif_desc_t d;
		logic               skip;
		logic [8:0]         cmd;
		d    = '0;
		skip = h[`CIF_SKIP_BIT];
		cmd  = h[`CIF_REW_CMD_LSB+`CIF_REW_CMD_W-1:`CIF_REW_CMD_LSB];
		d.analyzer_skip       = skip;
		d.rewriter_value      = h[`CIF_REWRITER_VALUE_LSB+`CIF_REWRITER_VALUE_W-1:`CIF_REWRITER_VALUE_LSB];
		d.ingress_port_number = h[`CIF_INGRESS_PORT_NUMBER_LSB+`CIF_INGRESS_PORT_NUMBER_W-1:`CIF_INGRESS_PORT_NUMBER_LSB];
		d.core_port           = `CIF_CORE_PORT;
		d.cpu_port            = grp ? `CIF_PORT_B : `CIF_CORE_PORT;
		d.cpu_source_precedence = pref;
		if (skip)
		begin
			d.forward_port_mask   = h[`CIF_FWD_MASK_LSB+`CIF_FWD_MASK_W-1:`CIF_FWD_MASK_LSB];
			d.host_queue_field    = h[`CIF_HOSTQ_LSB+`CIF_HOSTQ_W-1:`CIF_HOSTQ_LSB];
			d.traffic_class_field = h[`CIF_QOS_LSB+`CIF_QOS_W-1:`CIF_QOS_LSB];
			d.tag_pop_count       = h[`CIF_POP_LSB+`CIF_POP_W-1:`CIF_POP_LSB];
			d.tag_protocol_select = h[`CIF_TPID_BIT];
			d.pcp                 = h[`CIF_PCP_LSB+`CIF_PCP_W-1:`CIF_PCP_LSB];
			d.dei                 = h[`CIF_DEI_BIT];
			d.vid                 = h[`CIF_VID_LSB+`CIF_VID_W-1:`CIF_VID_LSB];
			d.rewriter_command    = cmd;
			d.smac_replace        = h[`CIF_B126_BIT];
			d.mac_swap            = (cmd[3:0] == `CIF_OP4_SWAP);
			d.dscp_remark         = (cmd[2:0] == `CIF_OP3_DSCP);
			d.ptp_one_step        = (cmd[2:0] == `CIF_OP3_PTP1);
			d.egress_delay_add    = (cmd[2:0] == `CIF_OP3_PTP1) & cmd[`CIF_CMD_EGR_DLY];
			d.ptp_two_step        = (cmd[2:0] == `CIF_OP3_PTP2);
			d.ptp_origin          = (cmd[2:0] == `CIF_OP3_ORIGIN);
			d.op_arg              = cmd[8:3];
		end
		else
		begin
			d.port_impersonation_enable = h[`CIF_B126_BIT];
			d.impersonated_port_number  = h[`CIF_IMPERSONATED_PORT_NUMBER_LSB+`CIF_IMPERSONATED_PORT_NUMBER_W-1:`CIF_IMPERSONATED_PORT_NUMBER_LSB];
		end
		return d;
	endfunction : decode_hdr

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				r[8*i +: 8] = nw[8*i +: 8];
		end
		return r;
	endfunction : merge

	cif_pkg::cif_state_t st_q, st_d;
	logic                grp_q, grp_d;
	logic                rr_q, rr_d;
	logic [2:0]          hcnt_q, hcnt_d;
	logic [159:0]        hdr_q, hdr_d;
	logic                first_q, first_d;
	logic [1:0]          in_ready_d;
	logic                out_valid_d;
	logic [31:0]         ctrl_q, ctrl_d;
	logic [31:0]         smac_lo_q, smac_lo_d;
	logic [31:0]         smac_hi_q, smac_hi_d;
	logic [1:0]          runt_q, runt_d;
	logic [31:0]         frm_q [2];
	logic                aw_full_q, w_full_q;
	logic [7:0]          awaddr_q;
	logic [31:0]         wdata_q;
	logic [3:0]          wstrb_q;

	// Stream datapath decode
	wire                 take      = in_valid[grp_q] & in_ready[grp_q];
	wire cif_pkg::cif_beat_t cur   = in_beat[grp_q];
	wire                 hdr_take  = take & (st_q == cif_pkg::ST_HDR);
	wire                 body_take = take & (st_q == cif_pkg::ST_BODY);
	wire                 out_fire  = out_valid & out_ready;
	wire                 pick      = (in_valid[1] & ~in_valid[0]) | (in_valid[1] & in_valid[0] & ~rr_q);
	wire [1:0]           hdr_en    = {ctrl_q[`CIF_CTRL_HDR_EN1], ctrl_q[`CIF_CTRL_HDR_EN0]};
	wire                 frm_end   = body_take & cur.last;
	wire                 runt_hit  = hdr_take & cur.last;

	// Frame sequencing: round-robin between groups per frame, header beats swallowed
	always_comb
	begin
		st_d    = st_q;
		grp_d   = grp_q;
		rr_d    = rr_q;
		hcnt_d  = hcnt_q;
		hdr_d   = hdr_q;
		first_d = first_q & ~body_take;
		case (st_q)
			cif_pkg::ST_IDLE:
			begin
				if (|in_valid)
				begin
					grp_d   = pick;
					rr_d    = pick;
					hcnt_d  = 3'h0;
					hdr_d   = '0;
					first_d = 1'b1;
					st_d    = hdr_en[pick] ? cif_pkg::ST_HDR : cif_pkg::ST_BODY;
				end
			end
			cif_pkg::ST_HDR:
			begin
				if (hdr_take)
				begin
					hdr_d  = {hdr_q[127:0], cur.data};
					hcnt_d = hcnt_q + 3'h1;
					if (cur.last)
						st_d = cif_pkg::ST_IDLE;
					else if (hcnt_q == `CIF_HDR_WORDS - 3'h1)
						st_d = cif_pkg::ST_BODY;
				end
			end
			cif_pkg::ST_BODY:
			begin
				if (frm_end)
					st_d = cif_pkg::ST_IDLE;
			end
			default:
				st_d = cif_pkg::ST_IDLE;
		endcase
	end

	// Output slot is one beat; ready is raised only for the active group while the slot will be empty
	assign out_valid_d   = body_take | (out_valid & ~out_fire);
	assign in_ready_d[0] = (st_d != cif_pkg::ST_IDLE) & ~grp_d & ~out_valid_d;
	assign in_ready_d[1] = (st_d != cif_pkg::ST_IDLE) & grp_d & ~out_valid_d;

	// Sequencer registers
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_q     <= cif_pkg::ST_IDLE;
			grp_q    <= 1'b0;
			rr_q     <= 1'b0;
			hcnt_q   <= 3'h0;
			hdr_q    <= '0;
			first_q  <= 1'b0;
			in_ready <= 2'h0;
		end
		else
		begin
			st_q     <= st_d;
			grp_q    <= grp_d;
			rr_q     <= rr_d;
			hcnt_q   <= hcnt_d;
			hdr_q    <= hdr_d;
			first_q  <= first_d;
			in_ready <= in_ready_d;
		end
	end

	// Output beat; descriptor latched with the first payload beat only
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			out_valid <= 1'b0;
			out_beat  <= '0;
			out_sof   <= 1'b0;
			out_desc  <= '0;
		end
		else
		begin
			out_valid <= out_valid_d;
			if (body_take)
			begin
				out_beat <= cur;
				out_sof  <= first_q;
			end
			if (body_take & first_q)
				out_desc <= decode_hdr(hdr_q[127:0], grp_q, ctrl_q[`CIF_CTRL_PREFER]);
		end
	end

	// Per-group frame counters and runt flags; a new runt beats a same-cycle clear
	wire wr_do = aw_full_q & w_full_q & ~s_axi_bvalid;
	wire stat_clr = wr_do & (awaddr_q == `CIF_REG_STATUS);
	generate
		for (genvar g = 0; g < 2; g++)
		begin : g_grp
			wire hit = (grp_q == 1'(g));
			assign runt_d[g] = (runt_q[g] & ~(stat_clr & wstrb_q[0] & wdata_q[`CIF_STAT_RUNT0+g])) | (runt_hit & hit);
			always_ff @(posedge clk or posedge rst)
			begin
				if (rst)
					frm_q[g] <= 32'h00000000;
				else if (frm_end & hit)
					frm_q[g] <= frm_q[g] + 32'h00000001;
			end
		end
	endgenerate

	// AXI4-Lite write: address and data latched independently, response after both
	wire aw_hs = s_axi_awvalid & s_axi_awready;
	wire w_hs  = s_axi_wvalid & s_axi_wready;
	wire aw_full_d = (aw_full_q | aw_hs) & ~wr_do;
	wire w_full_d  = (w_full_q | w_hs) & ~wr_do;
	wire wr_map = (awaddr_q == `CIF_REG_CTRL) | (awaddr_q == `CIF_REG_STATUS) | (awaddr_q == `CIF_REG_FRM0)
		| (awaddr_q == `CIF_REG_FRM1) | (awaddr_q == `CIF_REG_SMAC_LO) | (awaddr_q == `CIF_REG_SMAC_HI);
	assign ctrl_d    = (wr_do & (awaddr_q == `CIF_REG_CTRL)) ? merge(ctrl_q, wdata_q, wstrb_q) : ctrl_q;
	assign smac_lo_d = (wr_do & (awaddr_q == `CIF_REG_SMAC_LO)) ? merge(smac_lo_q, wdata_q, wstrb_q) : smac_lo_q;
	assign smac_hi_d = (wr_do & (awaddr_q == `CIF_REG_SMAC_HI)) ? merge(smac_hi_q, wdata_q, wstrb_q) : smac_hi_q;

	// AXI4-Lite read decode; unmapped offsets read zero with SLVERR
	wire ar_hs = s_axi_arvalid & s_axi_arready;
	wire rd_busy_d = ar_hs | (s_axi_rvalid & ~s_axi_rready);
	wire [31:0] stat_word = {22'h000000, grp_q, (st_q != cif_pkg::ST_IDLE), 6'h00, runt_q};
	wire rd_map = (s_axi_araddr == `CIF_REG_CTRL) | (s_axi_araddr == `CIF_REG_STATUS)
		| (s_axi_araddr == `CIF_REG_FRM0) | (s_axi_araddr == `CIF_REG_FRM1)
		| (s_axi_araddr == `CIF_REG_SMAC_LO) | (s_axi_araddr == `CIF_REG_SMAC_HI);
	wire [31:0] rd_word =
		(s_axi_araddr == `CIF_REG_CTRL)    ? {27'h0000000, ctrl_q[`CIF_CTRL_PREFER], 2'h0, hdr_en} :
		(s_axi_araddr == `CIF_REG_STATUS)  ? stat_word :
		(s_axi_araddr == `CIF_REG_FRM0)    ? frm_q[0] :
		(s_axi_araddr == `CIF_REG_FRM1)    ? frm_q[1] :
		(s_axi_araddr == `CIF_REG_SMAC_LO) ? smac_lo_q :
		(s_axi_araddr == `CIF_REG_SMAC_HI) ? {16'h0000, smac_hi_q[15:0]} : 32'h00000000;

	// Register bus state
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			aw_full_q     <= 1'b0;
			w_full_q      <= 1'b0;
			awaddr_q      <= 8'h00;
			wdata_q       <= 32'h00000000;
			wstrb_q       <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= RESP_OKAY;
		end
		else
		begin
			aw_full_q     <= aw_full_d;
			w_full_q      <= w_full_d;
			s_axi_awready <= ~aw_full_d;
			s_axi_wready  <= ~w_full_d;
			if (aw_hs)
				awaddr_q <= {s_axi_awaddr[7:2], 2'h0};
			if (w_hs)
			begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_do)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			s_axi_arready <= ~rd_busy_d;
			if (ar_hs)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_map ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// Configuration registers and their exported copies
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_q                <= `CIF_CTRL_RST;
			smac_lo_q             <= 32'h00000000;
			smac_hi_q             <= 32'h00000000;
			runt_q                <= 2'h0;
			egress_smac           <= `CIF_SMAC_RST;
			cpu_source_precedence <= 1'b0;
		end
		else
		begin
			ctrl_q                <= ctrl_d;
			smac_lo_q             <= smac_lo_d;
			smac_hi_q             <= smac_hi_d;
			runt_q                <= runt_d;
			egress_smac           <= {smac_hi_d[15:0], smac_lo_d};
			cpu_source_precedence <= ctrl_d[`CIF_CTRL_PREFER];
		end
	end

endmodule : cif_inject

/* File: cif_defs.svh */
// Purpose: Constants for the CPU frame injection header parser.
// Assumes: 32-bit beats; header is five beats, most significant beat first.
// Notes:   Header bit n of the 160-bit header is captured bit n.
`ifndef CIF_DEFS_SVH
`define CIF_DEFS_SVH

`define CIF_HDR_BYTES      20
`define CIF_HDR_WORDS      3'h5
`define CIF_CORE_PORT      4'hb
`define CIF_PORT_B         4'hc
// Header field positions and widths
`define CIF_SKIP_BIT       127
`define CIF_B126_BIT       126
`define CIF_IMPERSONATED_PORT_NUMBER_LSB  122
`define CIF_IMPERSONATED_PORT_NUMBER_W    4
`define CIF_REW_CMD_LSB    117
`define CIF_REW_CMD_W      9
`define CIF_REWRITER_VALUE_LSB    85
`define CIF_REWRITER_VALUE_W      32
`define CIF_FWD_MASK_LSB   56
`define CIF_FWD_MASK_W     12
`define CIF_INGRESS_PORT_NUMBER_LSB   43
`define CIF_INGRESS_PORT_NUMBER_W     4
`define CIF_POP_LSB        28
`define CIF_POP_W          2
`define CIF_HOSTQ_LSB      20
`define CIF_HOSTQ_W        8
`define CIF_QOS_LSB        17
`define CIF_QOS_W          3
`define CIF_TPID_BIT       16
`define CIF_PCP_LSB        13
`define CIF_PCP_W          3
`define CIF_DEI_BIT        12
`define CIF_VID_LSB        0
`define CIF_VID_W          12
// Rewriter command encodings
`define CIF_OP4_SWAP       4'h8
`define CIF_OP3_DSCP       3'h1
`define CIF_OP3_PTP1       3'h2
`define CIF_OP3_PTP2       3'h3
`define CIF_OP3_ORIGIN     3'h5
`define CIF_CMD_EGR_DLY    5
// Register byte offsets
`define CIF_REG_CTRL       8'h00
`define CIF_REG_STATUS     8'h04
`define CIF_REG_FRM0       8'h08
`define CIF_REG_FRM1       8'h0c
`define CIF_REG_SMAC_LO    8'h10
`define CIF_REG_SMAC_HI    8'h14
// Control and status bit positions, reset values
`define CIF_CTRL_HDR_EN0   0
`define CIF_CTRL_HDR_EN1   1
`define CIF_CTRL_PREFER    4
`define CIF_STAT_RUNT0     0
`define CIF_STAT_BUSY      8
`define CIF_STAT_GRP       9
`define CIF_CTRL_RST       32'h00000000
`define CIF_SMAC_RST       48'h000000000000

`endif

/* File: cif_pkg.sv */
// Purpose: Types for the CPU frame injection header parser.
// Assumes: Constants come from cif_defs.svh.
// Notes:   Descriptor travels with the first payload beat.
package cif_pkg;

	typedef struct packed {
		logic [31:0] data;
		logic [1:0]  mod;   // Valid bytes on last beat, 0 means four
		logic        last;
	} cif_beat_t;

	typedef struct packed {
		logic        analyzer_skip;
		logic [11:0] forward_port_mask;
		logic [7:0]  host_queue_field;
		logic [2:0]  traffic_class_field;
		logic [1:0]  tag_pop_count;
		logic        tag_protocol_select;
		logic [2:0]  pcp;
		logic        dei;
		logic [11:0] vid;
		logic        port_impersonation_enable;
		logic [3:0]  impersonated_port_number;
		logic [8:0]  rewriter_command;
		logic [31:0] rewriter_value;
		logic [3:0]  ingress_port_number;
		logic [3:0]  core_port;
		logic [3:0]  cpu_port;
		logic        cpu_source_precedence;
		logic        smac_replace;
		logic        mac_swap;
		logic        dscp_remark;
		logic        ptp_one_step;
		logic        egress_delay_add;
		logic        ptp_two_step;
		logic [5:0]  op_arg;
		logic        ptp_origin;
	} cif_desc_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_HDR,
		ST_BODY
	} cif_state_t;

endpackage : cif_pkg

/* File: cif_props.sv */
// Purpose: Port assertions for the injection header parser.
// Assumes: One clock domain, async active-high reset.
// Notes:   Descriptor field checks look only at frame starts; desc_stable_a checks it holds inside a frame.
`timescale 1ns/10ps
module cif_props (
	input wire logic               clk,
	input wire logic               rst,
	input wire logic               out_valid,
	input wire logic               out_ready,
	input wire cif_pkg::cif_beat_t out_beat,
	input wire logic               out_sof,
	input wire cif_pkg::cif_desc_t out_desc,
	input wire logic               cpu_source_precedence
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Frame start qualifiers and command shorthand
	wire logic               go = out_valid && out_sof;
	wire cif_pkg::cif_desc_t d  = out_desc;
	wire logic               sk = go && d.analyzer_skip;
	wire logic [8:0]         op = d.rewriter_command;

	hold_beat_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_beat))
		else $error("out beat changed while stalled");
	desc_stable_a: assert property (out_valid && !out_sof |-> $stable(out_desc))
		else $error("descriptor moved inside frame");
	core_port_a: assert property (go |-> d.core_port == 4'hb)
		else $error("core port not 11");
	cpu_group_a: assert property (go |-> d.cpu_port inside {4'hb, 4'hc})
		else $error("cpu port not a group port");
	prec_copy_a: assert property (go |-> d.cpu_source_precedence == cpu_source_precedence)
		else $error("precedence not copied");
	analysis_clear_a: assert property (go && !d.analyzer_skip |-> d.forward_port_mask == 12'h0 && op == 9'h0)
		else $error("bypass fields set on analysed frame");
	skip_port_impersonation_enable_a: assert property (sk |-> !d.port_impersonation_enable)
		else $error("impersonation with skip");
	mac_swap_a: assert property (sk |-> d.mac_swap == (op[3:0] == 4'h8))
		else $error("swap decode wrong");
	dscp_dec_a: assert property (sk |-> d.dscp_remark == (op[2:0] == 3'h1) && d.op_arg == op[8:3])
		else $error("dscp decode wrong");
	one_step_a: assert property (sk |-> d.ptp_one_step == (op[2:0] == 3'h2)
		&& d.egress_delay_add == (op[2:0] == 3'h2 && op[5]))
		else $error("one-step decode wrong");
	two_step_a: assert property (sk |-> d.ptp_two_step == (op[2:0] == 3'h3))
		else $error("two-step decode wrong");
	origin_ts_a: assert property (sk |-> d.ptp_origin == (op[2:0] == 3'h5))
		else $error("origin decode wrong");
endmodule : cif_props

bind cif_inject cif_props i_props (.clk, .rst, .out_valid, .out_ready, .out_beat, .out_sof, .out_desc,
	.cpu_source_precedence);

/* File: cif_host_model.sv */
// Purpose: Host model writing frames into one injection group.
// Assumes: Bench pushes whole frames, header first, into q.
// Notes:   Data lines show inverted junk while valid is low.
`timescale 1ns/10ps
module cif_host_model (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic          ready,
	output logic               valid,
	output cif_pkg::cif_beat_t beat
);
	cif_pkg::cif_beat_t q[$];
	int                 gap = 0;
	int                 idle_n = 0;
	// Offer a beat, hold it until taken, then pause gap cycles
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			valid <= 1'b0;
			beat <= '0;
			idle_n = 0;
		end
		else if (!valid || ready)
		begin
			if (q.size() != 0 && idle_n == 0)
			begin
				valid <= 1'b1;
				beat <= q.pop_front();
				idle_n = gap;
			end
			else
			begin
				valid <= 1'b0;
				beat <= ~beat; // Released lines do not keep old data
				if (idle_n > 0)
					idle_n--;
			end
		end
	end
endmodule : cif_host_model

/* File: cif_inject_tb.sv */
// Purpose: Self-checking bench for the injection header parser.
// Assumes: Host models feed both groups; the core side stalls at random.
// Notes:   Expected beats and descriptors come from a queue model.
`timescale 1ns/10ps
`define CHK(nm, ex, sn) begin compares++; if ((ex) !== (sn)) begin failures++; \
	$display("[ERR] %s exp %h got %h", nm, ex, sn); end end
module cif_inject_tb;
	logic                     clk = 1'b0, rst = 1'b1, stall = 1'b0;
	logic [7:0]               s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0]              s_axi_wdata = '0, s_axi_rdata, lf = 32'h2, rv;
	logic [3:0]               s_axi_wstrb = '0;
	logic                     s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic                     s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic                     s_axi_rvalid, out_valid, out_sof, out_ready = 1'b1, cpu_source_precedence;
	logic [1:0]               s_axi_bresp, s_axi_rresp, in_ready, en = 2'h0;
	wire [1:0]                in_valid;
	wire cif_pkg::cif_beat_t [1:0] in_beat;
	cif_pkg::cif_beat_t       out_beat;
	cif_pkg::cif_desc_t       out_desc, ed, dq[2][$];
	logic [35:0]              eb, bq[2][$];
	logic [47:0]              egress_smac;
	logic                     prec_m = 1'b0;
	int                       failures = 0, compares = 0, fc[2] = '{0, 0}, cur = 0;
	logic [8:0]               cmds[7] = '{9'h000, 9'h008, 9'h0e9, 9'h002, 9'h022, 9'h01b, 9'h005};

	cif_inject i_dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .in_valid, .in_beat, .in_ready,
		.out_valid, .out_beat, .out_sof, .out_desc, .out_ready, .egress_smac, .cpu_source_precedence);
	cif_host_model i_h0 (.clk, .rst, .ready(in_ready[0]), .valid(in_valid[0]), .beat(in_beat[0]));
	cif_host_model i_h1 (.clk, .rst, .ready(in_ready[1]), .valid(in_valid[1]), .beat(in_beat[1]));

	initial forever #5 clk = ~clk;

	function logic [31:0] rnd();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf;
	endfunction : rnd

	task end_sim;
		if (failures == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim

	// AXI4-Lite master: both channels offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		`CHK("bresp", er, s_axi_bresp)
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		`CHK("rdata", e, d)
		`CHK("rresp", er, r)
	endtask : rc

	// Reference descriptor; host fields not used by the path read as zero
	function automatic cif_pkg::cif_desc_t edesc(input logic [127:0] h, input int g);
		cif_pkg::cif_desc_t e;
		logic [8:0]         c;
		c = h[125:117];
		e = '0;
		e.analyzer_skip = h[127];
		e.rewriter_value = h[116:85];
		e.ingress_port_number = h[46:43];
		e.core_port = 4'hb;
		e.cpu_port = g ? 4'hc : 4'hb;
		e.cpu_source_precedence = prec_m;
		if (h[127])
		begin
			{e.forward_port_mask, e.host_queue_field} = {h[67:56], h[27:20]};
			{e.tag_pop_count, e.traffic_class_field, e.tag_protocol_select, e.pcp, e.dei, e.vid} = {h[29:28], h[19:0]};
			e.smac_replace = h[126];
			e.rewriter_command = c;
			e.mac_swap = c[3:0] == 4'h8;
			e.dscp_remark = c[2:0] == 3'h1;
			e.ptp_one_step = c[2:0] == 3'h2;
			e.egress_delay_add = c[2:0] == 3'h2 && c[5];
			e.ptp_two_step = c[2:0] == 3'h3;
			e.ptp_origin = c[2:0] == 3'h5;
			e.op_arg = c[8:3];
		end
		else
			{e.port_impersonation_enable, e.impersonated_port_number} = h[126:122];
		return e;
	endfunction : edesc

	task automatic put(input int g, input cif_pkg::cif_beat_t b);
		if (g != 0)
			i_h1.q.push_back(b);
		else
			i_h0.q.push_back(b);
	endtask : put

	// Queue one frame; n payload beats, n of 0 makes a frame cut inside the header
	task automatic send(input int g, input logic [127:0] h, input int n);
		cif_pkg::cif_beat_t b;
		logic [159:0]       hw;
		hw = {rnd(), h};
		for (int i = 0; i < 5 && en[g]; i++)
			if (n > 0 || i < 3)
			begin
				b = '{data: hw[159 - 32 * i -: 32], mod: 2'h0, last: n == 0 && i == 2};
				put(g, b);
			end
		for (int i = 0; i < n; i++)
		begin
			hw[31:0] = rnd();
			b = '{data: hw[31:0], mod: hw[1:0], last: i == n - 1};
			put(g, b);
			bq[g].push_back({i == 0, b});
		end
		if (n > 0)
		begin
			fc[g]++;
			dq[g].push_back(edesc(en[g] ? h : 128'h0, g));
		end
	endtask : send

	task automatic drain;
		for (int i = 0; i < 4000 && (bq[0].size() + bq[1].size() + i_h0.q.size() + i_h1.q.size() != 0
			|| in_valid != 2'h0 || i < 20); i++)
			@(posedge clk);
	endtask : drain

	// Core side: random stalls, every beat checked against the model
	always @(posedge clk)
	begin
		rv = rnd();
		out_ready <= !stall || rv[0];
		if (!rst && out_valid && out_ready)
		begin
			if (out_sof) cur = out_desc.cpu_port == 4'hc;
			if (out_sof) ed = dq[cur].pop_front();
			if (out_sof) `CHK("desc", ed, out_desc)
			eb = bq[cur].pop_front();
			`CHK("beat", eb, {out_sof, out_beat})
		end
	end

	initial
	begin
		#300us;
		failures++;
		end_sim();
	end

	initial
	begin
		logic [127:0] h;
		logic [31:0]  d;
		logic [1:0]   r;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		`CHK("smac", 48'h0, egress_smac)
		rc(8'h00, 32'h0, 2'h0);
		rc(8'h20, 32'h0, 2'h2);
		wr(8'h20, 32'h1, 4'hf, 2'h2);
		wr(8'h00, 32'h13, 4'hf, 2'h0);
		en = 2'h3;
		prec_m = 1'b1;
		rc(8'h00, 32'h13, 2'h0);
		`CHK("prec", 1'b1, cpu_source_precedence)
		wr(8'h10, 32'h89abcdef, 4'hf, 2'h0);
		wr(8'h10, 32'h00001234, 4'h3, 2'h0);
		wr(8'h14, 32'h00005566, 4'hf, 2'h0);
		rc(8'h10, 32'h89ab1234, 2'h0);
		`CHK("smac", 48'h556689ab1234, egress_smac)
		// Every rewriter command, bypass set, alternating groups
		foreach (cmds[i])
		begin
			h = {rnd(), rnd(), rnd(), rnd()};
			h[127] = 1'b1;
			h[125:117] = cmds[i];
			{h[84:68], h[55:47], h[42:30]} = '0;
			h[46:43] = 4'(i + 6);
			send(i % 2, h, 1 + i % 3);
		end
		drain();
		// Analysis path with impersonation, header off on group 1, then a short frame
		wr(8'h00, 32'h1, 4'hf, 2'h0);
		en = 2'h1;
		prec_m = 1'b0;
		h = {rnd(), rnd(), rnd(), rnd()};
		h[127:126] = 2'h1;
		send(0, h, 2);
		send(1, h, 3);
		send(0, h, 0);
		drain();
		rd(8'h04, d, r);
		`CHK("runt", 2'h1, d[1:0])
		wr(8'h04, 32'h1, 4'h1, 2'h0);
		rd(8'h04, d, r);
		`CHK("runt", 2'h0, d[1:0])
		// Both groups at once, host pauses and core stalls
		wr(8'h00, 32'h3, 4'hf, 2'h0);
		en = 2'h3;
		stall = 1'b1;
		i_h1.gap = 2;
		for (int i = 0; i < 6; i++)
		begin
			h = {rnd(), rnd(), rnd(), rnd()};
			h[127] = 1'b0;
			send(i % 2, h, 4);
		end
		drain();
		rc(8'h08, 32'(fc[0]), 2'h0);
		rc(8'h0c, 32'(fc[1]), 2'h0);
		end_sim();
	end
endmodule : cif_inject_tb
